/* File: src/hub_port_force_sense.sv */
// Purpose: Forces downstream USB pairs to J, K or SE0, pulls lines low, and senses line state.
// Assumes: Line inputs and repeater drive are synchronous to aclk; AXI4-Lite register access.
// Notes: Pad drive outputs follow their cause by one clock edge.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "hub_port_force_defines.svh"

// Function
// - Force field zero leaves the port under normal repeater drive.
// - Field one drives J, two drives K, three drives SE0.
// - Force-low register pulls each D+ and D- low individually.
// - Force-low lines are driven with edge-rate control off.
// - Force-low drive stays active while the hub is suspended.
// - Data status shows differential state only, independent of port speed.
// - During SE0 the data status keeps the last differential value.
// - SE0 and data status clear on chip reset and bus reset.
// - SE0 status reads one during SE0; read-only; upper bits zero.
// - Data status reads one when D+ above D-, zero when below.
// - Field forcing uses edge rate matching the port's configured speed.
module hub_port_force_sense #(
  parameter int N_PORTS = 4,
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic usb_bus_reset,
  input wire logic hub_suspend,
  input wire logic [N_PORTS-1:0] port_low_speed,
  input wire hub_port_force_pkg::line_pair_t [N_PORTS-1:0] line_in,
  input wire hub_port_force_pkg::pad_drive_t [N_PORTS-1:0] repeater_drive,
  output hub_port_force_pkg::pad_drive_t [N_PORTS-1:0] pad_drive
);

  // Elaboration check: eight-bit registers hold at most four ports.
  if (N_PORTS < 1 || N_PORTS > 4) begin : g_bad_ports
    $error("N_PORTS must lie between 1 and 4");
  end
  if (ADDR_W < 10) begin : g_bad_addr
    $error("ADDR_W must be at least 10");
  end

  // Maps a byte address onto a register; unaligned or unknown gives none.
  function automatic hub_port_force_pkg::reg_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-3:0] idx;
    idx = a[ADDR_W-1:2];
    if (a[1:0] != 2'h0) begin
      return hub_port_force_pkg::SEL_NONE;
    end
    if (idx == (ADDR_W-2)'(`HUB_IDX_FORCE_CTL)) begin
      return hub_port_force_pkg::SEL_FORCE_CTL;
    end
    if (idx == (ADDR_W-2)'(`HUB_IDX_SE0_STATUS)) begin
      return hub_port_force_pkg::SEL_SE0;
    end
    if (idx == (ADDR_W-2)'(`HUB_IDX_DIFF_DATA)) begin
      return hub_port_force_pkg::SEL_DIFF;
    end
    if (idx == (ADDR_W-2)'(`HUB_IDX_FORCE_LOW)) begin
      return hub_port_force_pkg::SEL_FORCE_LOW;
    end
    return hub_port_force_pkg::SEL_NONE;
  endfunction

  // Returns the two-bit pair belonging to port p.
  function automatic logic [1:0] port_pair(input logic [7:0] v, input int p);
    return v[2*p +: 2];
  endfunction

  logic [7:0] force_ctl_reg;
  logic [7:0] force_low_reg;
  logic [N_PORTS-1:0] se0_reg;
  logic [N_PORTS-1:0] diff_reg;
  logic [N_PORTS-1:0] se0_now;
  logic [N_PORTS-1:0] diff_valid;
  logic [N_PORTS-1:0] dp_now;
  logic [N_PORTS-1:0] diff_next;
  hub_port_force_pkg::pad_drive_t [N_PORTS-1:0] pad_reg;
  hub_port_force_pkg::pad_drive_t [N_PORTS-1:0] pad_next;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [31:0] rdata_reg;
  logic [ADDR_W-1:0] waddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic do_write;
  hub_port_force_pkg::reg_sel_t wsel;
  hub_port_force_pkg::reg_sel_t rsel;

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign pad_drive = pad_reg;

  // The write takes effect once address and data are both held and no answer is pending.
  assign do_write = !awready_reg && !wready_reg && !bvalid_reg;
  assign wsel = reg_sel(waddr_q);
  assign rsel = reg_sel(s_axi_araddr);

  // Write address and data channels are taken independently and held until the answer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      waddr_q <= '0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        awready_reg <= 1'b0;
        waddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
        wready_reg <= 1'b0;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (bvalid_reg && s_axi_bready) begin
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // Write response; unknown addresses answer with an error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `HUB_RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wsel == hub_port_force_pkg::SEL_NONE) ? `HUB_RESP_SLVERR : `HUB_RESP_OKAY;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Force registers; bus reset leaves both untouched.
  // Kept across bus reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      force_ctl_reg <= `HUB_RST_FORCE_CTL;
      force_low_reg <= `HUB_RST_FORCE_LOW;
    end else if (do_write && wstrb0_q) begin
      if (wsel == hub_port_force_pkg::SEL_FORCE_CTL) begin
        force_ctl_reg <= wdata_q;
      end
      if (wsel == hub_port_force_pkg::SEL_FORCE_LOW) begin
        force_low_reg <= wdata_q;
      end
    end
  end

  // Read channel; the status registers ignore writes and pad their upper bits with zero.
  // Read-only with zero upper bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= `HUB_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (s_axi_arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= `HUB_RESP_OKAY;
      case (rsel)
        hub_port_force_pkg::SEL_FORCE_CTL: begin
          rdata_reg <= {24'h00_0000, force_ctl_reg};
        end
        hub_port_force_pkg::SEL_FORCE_LOW: begin
          rdata_reg <= {24'h00_0000, force_low_reg};
        end
        hub_port_force_pkg::SEL_SE0: begin
          rdata_reg <= 32'(se0_reg);
        end
        hub_port_force_pkg::SEL_DIFF: begin
          rdata_reg <= 32'(diff_reg);
        end
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= `HUB_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Line classification: SE0 both low, differential when the lines differ.
  // Speed setting plays no part here.
  always_comb begin
    for (int p = 0; p < N_PORTS; p++) begin
      se0_now[p] = !line_in[p].dp && !line_in[p].dm;
      diff_valid[p] = line_in[p].dp ^ line_in[p].dm;
      dp_now[p] = line_in[p].dp;
    end
  end

  assign diff_next = (diff_valid & dp_now) | (~diff_valid & diff_reg);

  // Sensing registers, cleared on chip reset and on bus reset.
  // Both resets clear.
  always_ff @(posedge aclk) begin
    if (!aresetn || usb_bus_reset) begin
      se0_reg <= N_PORTS'(`HUB_RST_SENSE);
      diff_reg <= N_PORTS'(`HUB_RST_SENSE);
    end else begin
      se0_reg <= se0_now;
      diff_reg <= diff_next;
    end
  end

  // Per-line drive: force-low wins over the field, the field over the repeater.
  // Suspend is deliberately not an input to this decision.
  always_comb begin
    for (int p = 0; p < N_PORTS; p++) begin
      pad_next[p] = repeater_drive[p];
      case (port_pair(force_ctl_reg, p))
        `HUB_FORCE_DIFF1: begin
          pad_next[p] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, port_low_speed[p]};
        end
        `HUB_FORCE_DIFF0: begin
          pad_next[p] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, port_low_speed[p]};
        end
        `HUB_FORCE_SE0: begin
          pad_next[p] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, port_low_speed[p]};
        end
        default: begin
          pad_next[p] = repeater_drive[p];
        end
      endcase
      if (port_pair(force_low_reg, p) != 2'h0) begin
        if (port_pair(force_low_reg, p) == 2'h3 ||
            port_pair(force_ctl_reg, p) == `HUB_FORCE_NONE) begin
          pad_next[p].dp_oe = port_pair(force_low_reg, p) == 2'h3 ? 1'b1 : repeater_drive[p].dp_oe;
          pad_next[p].dm_oe = port_pair(force_low_reg, p) == 2'h3 ? 1'b1 : repeater_drive[p].dm_oe;
        end
        // Bit 2n-1 is D+, bit 2n-2 is D-.
        if (port_pair(force_low_reg, p) >= 2'h2) begin
          pad_next[p].dp_out = 1'b0;
          pad_next[p].dp_oe = 1'b1;
          pad_next[p].dp_edge_en = 1'b0;
        end
        if (port_pair(force_low_reg, p) == 2'h1 || port_pair(force_low_reg, p) == 2'h3) begin
          pad_next[p].dm_out = 1'b0;
          pad_next[p].dm_oe = 1'b1;
          pad_next[p].dm_edge_en = 1'b0;
        end
      end
    end
  end

  // Pad drive flops; force-low survives suspend since suspend never gates them.
  // Held during suspend.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_reg <= '0;
    end else begin
      pad_reg <= pad_next;
    end
  end

  // Per-port checks of the pad drive.
  for (genvar p = 0; p < N_PORTS; p++) begin : g_chk
    a_none_passes: assert property (@(posedge aclk) disable iff (!aresetn)
      (force_ctl_reg[2*p +: 2] == 2'h0 && force_low_reg[2*p +: 2] == 2'h0)
      |=> pad_reg[p] == $past(repeater_drive[p]))
      else $error("unforced port does not follow the repeater");
    a_force_j_drive: assert property (@(posedge aclk) disable iff (!aresetn)
      (force_ctl_reg[2*p +: 2] == 2'h1 && force_low_reg[2*p +: 2] == 2'h0)
      |=> pad_reg[p].dp_out && !pad_reg[p].dm_out && pad_reg[p].dp_oe && pad_reg[p].dm_oe)
      else $error("field one does not drive J");
    a_force_se0_drive: assert property (@(posedge aclk) disable iff (!aresetn)
      (force_ctl_reg[2*p +: 2] == 2'h3)
      |=> !pad_reg[p].dp_out && !pad_reg[p].dm_out && pad_reg[p].dp_oe && pad_reg[p].dm_oe)
      else $error("field three does not drive SE0");
    a_low_dp_plain: assert property (@(posedge aclk) disable iff (!aresetn)
      force_low_reg[2*p+1]
      |=> pad_reg[p].dp_oe && !pad_reg[p].dp_out && !pad_reg[p].dp_edge_en)
      else $error("force-low D+ not driven low without edge control");
    a_low_in_suspend: assert property (@(posedge aclk) disable iff (!aresetn)
      (hub_suspend && force_low_reg[2*p])
      |=> pad_reg[p].dm_oe && !pad_reg[p].dm_out)
      else $error("force-low D- released during suspend");
    a_edge_speed: assert property (@(posedge aclk) disable iff (!aresetn)
      (force_ctl_reg[2*p +: 2] != 2'h0)
      |=> pad_reg[p].low_speed == $past(port_low_speed[p]) && pad_reg[p].dp_edge_en ==
        !$past(force_low_reg[2*p+1]))
      else $error("field forcing edge rate does not match speed");
  end

  // Sense checks.
  a_diff_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (!usb_bus_reset && se0_now != '0)
    |=> (diff_reg & $past(se0_now)) == ($past(diff_reg) & $past(se0_now)))
    else $error("data status changed during SE0");
  a_diff_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    !usb_bus_reset |=> (diff_reg & $past(diff_valid)) == ($past(dp_now) & $past(diff_valid)))
    else $error("data status does not follow D+ on differential state");
  a_se0_track: assert property (@(posedge aclk) disable iff (!aresetn)
    !usb_bus_reset |=> se0_reg == $past(se0_now))
    else $error("SE0 status does not track the pair");
  a_sense_clear: assert property (@(posedge aclk)
    (!aresetn || usb_bus_reset) |=> se0_reg == '0 && diff_reg == '0)
    else $error("sense registers not cleared by reset");
  a_se0_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && arready_reg && rsel == hub_port_force_pkg::SEL_SE0)
    |=> rvalid_reg && rdata_reg == 32'($past(se0_reg)))
    else $error("SE0 status read returns wrong data");

endmodule // hub_port_force_sense

/* File: shared/hub_port_force_defines.svh */
// Purpose: Offsets, field codes and reset values of the downstream force and sense block.
// Assumes: Register indices are word indices; the byte address is four times the index.
// Notes: Definitions only.
`ifndef HUB_PORT_FORCE_DEFINES_SVH
`define HUB_PORT_FORCE_DEFINES_SVH

// Register word indices.
`define HUB_IDX_FORCE_CTL 8'h4b
`define HUB_IDX_SE0_STATUS 8'h4f
`define HUB_IDX_DIFF_DATA 8'h50
`define HUB_IDX_FORCE_LOW 8'h51

// Reset values of the registers.
`define HUB_RST_FORCE_CTL 8'h00
`define HUB_RST_FORCE_LOW 8'h00
`define HUB_RST_SENSE 4'h0

// Two-bit force field codes.
`define HUB_FORCE_NONE 2'h0
`define HUB_FORCE_DIFF1 2'h1
`define HUB_FORCE_DIFF0 2'h2
`define HUB_FORCE_SE0 2'h3

// AXI response codes.
`define HUB_RESP_OKAY 2'h0
`define HUB_RESP_SLVERR 2'h2

`endif

/* File: shared/hub_port_force_pkg.sv */
// Purpose: Types shared by the downstream force and sense block and its bench.
// Assumes: Four downstream ports, each a D+ and D- pair.
// Notes: Constants live in hub_port_force_defines.svh.
package hub_port_force_pkg;

  // Sensed level of one downstream pair.
  typedef struct packed {
    logic dp;
    logic dm;
  } line_pair_t;

  // Drive of one downstream pair with edge-rate control per line.
  typedef struct packed {
    logic dp_out;
    logic dm_out;
    logic dp_oe;
    logic dm_oe;
    logic dp_edge_en;
    logic dm_edge_en;
    logic low_speed;
  } pad_drive_t;

  // One-hot register selection.
  typedef enum logic [4:0] {
    SEL_NONE = 5'b00001,
    SEL_FORCE_CTL = 5'b00010,
    SEL_SE0 = 5'b00100,
    SEL_DIFF = 5'b01000,
    SEL_FORCE_LOW = 5'b10000
  } reg_sel_t;

endpackage

/* File: tb/usb_downstream_devices.sv */
// Purpose: Behavioural model of the USB devices on the four downstream pairs.
// Assumes: A driven line shows the hub's level; an undriven line shows the device's pull.
// Notes: Detached pairs fall to SE0 through the hub's pull-downs.
`timescale 1ns/1ps
module usb_downstream_devices (
  input wire hub_port_force_pkg::pad_drive_t [3:0] pad_drive,
  input wire logic [3:0] low_speed_dev,
  input wire logic attached,
  output hub_port_force_pkg::line_pair_t [3:0] line_in
);
  // A full-speed device pulls D+ up, a low-speed one D-; the hub wins where it drives.
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      line_in[p].dp = pad_drive[p].dp_oe ? pad_drive[p].dp_out : attached & ~low_speed_dev[p];
      line_in[p].dm = pad_drive[p].dm_oe ? pad_drive[p].dm_out : attached & low_speed_dev[p];
    end
  end
endmodule // usb_downstream_devices

/* File: tb/hub_port_force_sense_tb.sv */
// Purpose: Register-level test of downstream forcing and line sensing.
// Assumes: AXI4-Lite master tasks; byte address is four times the register index.
// Notes: Pad and sense results are sampled two edges after a write completes.
`timescale 1ns/1ps
`include "hub_port_force_defines.svh"
module hub_port_force_sense_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, usb_bus_reset, hub_suspend, attached;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0] port_low_speed;
  hub_port_force_pkg::line_pair_t [3:0] line_in;
  hub_port_force_pkg::pad_drive_t [3:0] repeater_drive, pad_drive;
  hub_port_force_pkg::pad_drive_t e;
  int n_mismatch, n_checks, cycles;
  localparam logic [11:0] CTL = {2'b00, `HUB_IDX_FORCE_CTL, 2'b00};
  localparam logic [11:0] SE0 = {2'b00, `HUB_IDX_SE0_STATUS, 2'b00};
  localparam logic [11:0] DIF = {2'b00, `HUB_IDX_DIFF_DATA, 2'b00};
  localparam logic [11:0] LOW = {2'b00, `HUB_IDX_FORCE_LOW, 2'b00};

  hub_port_force_sense DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .usb_bus_reset(usb_bus_reset), .hub_suspend(hub_suspend),
    .port_low_speed(port_low_speed), .line_in(line_in), .repeater_drive(repeater_drive),
    .pad_drive(pad_drive));

  usb_downstream_devices devs (.pad_drive(pad_drive), .low_speed_dev(port_low_speed),
    .attached(attached), .line_in(line_in));

  // Free-running 50 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Cuts a hung run short.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // Counts every comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One write; each channel is released at the edge that takes it.
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = awvalid & awready; tw = wvalid & wready; tb = bvalid;
      if (tb) chk({30'h0, bresp}, {30'h0, er});
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask

  // One read; data and response are compared with the expectation.
  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(negedge aclk);
      ta = arvalid & arready; tr = rvalid;
      if (tr) begin
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
      end
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask

  // Lets a register write reach the pads and the sensed state.
  task automatic settle();
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 12'h0; araddr = 12'h0; wdata = 32'h0; usb_bus_reset = 1'b0;
    hub_suspend = 1'b0; attached = 1'b0; port_low_speed = 4'h5; cycles = 0;
    n_mismatch = 0; n_checks = 0;
    for (int p = 0; p < 4; p++) repeater_drive[p] = {5'b10000, 2'(p)};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(CTL, 32'h0, `HUB_RESP_OKAY);
    axi_read(LOW, 32'h0, `HUB_RESP_OKAY);
    axi_read(DIF, 32'h0, `HUB_RESP_OKAY);
    axi_read(SE0, 32'h0f, `HUB_RESP_OKAY);
    axi_read(12'h000, 32'h0, `HUB_RESP_SLVERR);
    axi_write(12'h12d, 32'h0, `HUB_RESP_SLVERR);
    attached <= 1'b1;
    // Each port is forced through every field value in turn.
    for (int p = 0; p < 4; p++) begin
      for (int c = 0; c < 4; c++) begin
        axi_write(CTL, 32'(c) << (2 * p), `HUB_RESP_OKAY);
        settle();
        if (c == 0) e = repeater_drive[p];
        else e = {c == 1, c == 2, 4'hf, port_low_speed[p]};
        chk({25'h0, pad_drive[p]}, {25'h0, e});
      end
    end
    axi_write(CTL, 32'h0, `HUB_RESP_OKAY);
    hub_suspend <= 1'b1;
    for (int b = 0; b < 8; b++) begin
      axi_write(LOW, 32'h1 << b, `HUB_RESP_OKAY);
      settle();
      e = pad_drive[b / 2];
      if (b % 2 == 1) chk({29'h0, e.dp_out, e.dp_oe, e.dp_edge_en}, 32'h2);
      else chk({29'h0, e.dm_out, e.dm_oe, e.dm_edge_en}, 32'h2);
      axi_read(LOW, 32'h1 << b, `HUB_RESP_OKAY);
    end
    // SE0 on every port while suspended.
    axi_write(LOW, 32'hff, `HUB_RESP_OKAY);
    settle();
    axi_read(SE0, 32'h0f, `HUB_RESP_OKAY);
    axi_write(LOW, 32'h0, `HUB_RESP_OKAY);
    hub_suspend <= 1'b0;
    axi_write(CTL, 32'h55, `HUB_RESP_OKAY);
    settle();
    axi_read(DIF, 32'h0f, `HUB_RESP_OKAY);
    axi_read(SE0, 32'h00, `HUB_RESP_OKAY);
    port_low_speed <= 4'ha;
    settle();
    chk({31'h0, pad_drive[1].low_speed}, 32'h1);
    chk({31'h0, pad_drive[2].low_speed}, 32'h0);
    axi_read(DIF, 32'h0f, `HUB_RESP_OKAY);
    axi_write(CTL, 32'hff, `HUB_RESP_OKAY);
    settle();
    axi_read(DIF, 32'h0f, `HUB_RESP_OKAY);
    axi_write(SE0, 32'h00, `HUB_RESP_OKAY);
    axi_read(SE0, 32'h0f, `HUB_RESP_OKAY);
    @(posedge aclk);
    usb_bus_reset <= 1'b1;
    @(posedge aclk);
    usb_bus_reset <= 1'b0;
    axi_read(DIF, 32'h00, `HUB_RESP_OKAY);
    axi_read(CTL, 32'hff, `HUB_RESP_OKAY);
    axi_write(CTL, 32'h55, `HUB_RESP_OKAY);
    settle();
    axi_read(DIF, 32'h0f, `HUB_RESP_OKAY);
    axi_write(CTL, 32'haa, `HUB_RESP_OKAY);
    settle();
    axi_read(DIF, 32'h00, `HUB_RESP_OKAY);
    axi_write(CTL, 32'h0, `HUB_RESP_OKAY);
    settle();
    chk({25'h0, pad_drive[3]}, {25'h0, repeater_drive[3]});
    finish_test();
  end
endmodule // hub_port_force_sense_tb
